/* dmad_core.sv */
// Data memory decode, internal RAM, on-chip external RAM and pointers
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`include "dmad_params.svh"
// Behaviour
// RULE1: Flash spans zero to top address
// RULE2: Top address is lock byte; above reserved
// RULE3: Code reads flash; external writes EXTERNAL_SPACE_RAM unless enabled
// RULE4: 256 bytes internal RAM, lower half both modes
// RULE5: Upper direct to SFR, indirect to RAM
// RULE6: Four banks of eight, selected by status bits
// RULE7: Indirect pointer from bank register zero/one
// RULE8: Bytes 0x20-0x2F form 128 addressable bits
// RULE9: Bit versus byte chosen by instruction kind
// RULE10: Push writes above pointer, then increments
// RULE11: Reset loads stack pointer with 0x07
// RULE12: Stack anywhere in 256 bytes
// RULE13: 4096 bytes on-chip external-space RAM
// RULE14: 16-bit move addresses with full pointer
// RULE15: Data pointer readable as two bytes
// RULE16: 8-bit move uses page and index register
// RULE17: On-chip moves immediate; off-chip use timing
// RULE18: Software configures pins before off-chip access
// RULE19: Bank field 00..11 maps banks 0..3
// RULE20: Mode 00 wraps all moves onto EXTERNAL_SPACE_RAM
// RULE21: Pop reads at pointer, then decrements
module dmad_core
  import dmad_pkg::*;
#(
  parameter int EXTERNAL_SPACE_RAM_DEPTH = 4096,
  parameter logic [15:0] FLASH_TOP = 16'hfbff
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // CPU data request
  input wire dmad_req_t req_i,
  output logic ready_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  // CPU code read
  input wire logic [15:0] code_addr_i,
  output logic [15:0] code_flash_addr_o,
  output logic code_lock_o,
  output logic code_reserved_o,
  // SFR space
  output dmad_xfer_t sfr_o,
  input wire logic [7:0] sfr_rdata_i,
  // Flash write path
  output dmad_xfer_t flash_o,
  // Off-chip bus
  output dmad_xfer_t ext_o,
  input wire logic [7:0] ext_rdata_i
);
  localparam int XAW = $clog2(EXTERNAL_SPACE_RAM_DEPTH);

  logic [7:0] iram [0:255];
  logic [7:0] external_space_ram [0:EXTERNAL_SPACE_RAM_DEPTH-1];
  logic [7:0] psw_r, sp_r, dpl_r, dph_r, page_r, cfg_r, timing_r, cnt_r;
  logic [7:0] ext_s1_r, ext_s2_r;
  logic offchip_r, wb_ack_r;
  dmad_state_t state_r;
  logic [1:0] bank;
  logic [7:0] ri_addr, iaddr, iwdata, ibyte, rd_nxt;
  logic [15:0] xaddr;
  logic accept, iwe, sfr_sel, xmove, offchip, flash_wr, wb_wr;
  logic cflash, clock_hit, creserved;

  assign bank = psw_r[`DMAD_BANK_MSB:`DMAD_BANK_LSB]; // RULE6 RULE19
  assign ri_addr = {3'h0, bank, 2'h0, req_i.ri_sel}; // RULE7
  assign accept = req_i.valid && (state_r == ST_IDLE);
  assign ready_o = (state_r == ST_IDLE);
  assign xmove = (req_i.kind == K_XDP) || (req_i.kind == K_XRI);
  assign xaddr = (req_i.kind == K_XDP) ? {dph_r, dpl_r} : {page_r, iram[ri_addr]}; // RULE14 RULE16

  // Off-chip selection by interface mode
  always_comb
  begin
    unique case (cfg_r[`DMAD_MODE_MSB:`DMAD_MODE_LSB])
      `DMAD_MODE_ONCHIP: offchip = 1'b0; // RULE20
      `DMAD_MODE_OFFCHIP: offchip = 1'b1;
      default: offchip = (xaddr >= 16'(EXTERNAL_SPACE_RAM_DEPTH));
    endcase
  end

  // Flash takes external writes only when enabled
  assign flash_wr = cfg_r[`DMAD_CFG_FLASH_WE] && req_i.we; // RULE3

  // Internal RAM address decode
  always_comb
  begin
    iaddr = 8'h00;
    iwe = 1'b0;
    iwdata = req_i.wdata;
    sfr_sel = 1'b0;
    rd_nxt = 8'h00;
    ibyte = 8'h00;
    unique case (req_i.kind)
      K_DIRECT:
      begin
        iaddr = req_i.addr[7:0];
        sfr_sel = (req_i.addr[7:0] >= `DMAD_UPPER_BASE); // RULE5
        iwe = req_i.we && !sfr_sel; // RULE4
        rd_nxt = sfr_sel ? sfr_rdata_i : iram[iaddr];
      end
      K_INDIRECT:
      begin
        iaddr = iram[ri_addr]; // RULE5 RULE7
        iwe = req_i.we;
        rd_nxt = iram[iaddr];
      end
      K_BIT:
      begin
        sfr_sel = req_i.addr[7]; // RULE9
        iaddr = sfr_sel ? {req_i.addr[7:3], 3'h0} :
          (`DMAD_BIT_BASE + {4'h0, req_i.addr[6:3]}); // RULE8
        ibyte = sfr_sel ? sfr_rdata_i : iram[iaddr];
        iwdata = ibyte;
        iwdata[req_i.addr[2:0]] = req_i.wdata[0];
        iwe = req_i.we && !sfr_sel;
        rd_nxt = {7'h00, ibyte[req_i.addr[2:0]]};
      end
      K_REG:
      begin
        iaddr = {3'h0, bank, req_i.addr[2:0]}; // RULE6
        iwe = req_i.we;
        rd_nxt = iram[iaddr];
      end
      K_STACK:
      begin
        iaddr = req_i.we ? sp_r + 8'h01 : sp_r; // RULE10 RULE21 RULE12
        iwe = req_i.we;
        rd_nxt = iram[iaddr];
      end
      K_XDP, K_XRI:
      begin
        rd_nxt = external_space_ram[xaddr[XAW-1:0]]; // RULE13 RULE20
      end
      default:
      begin
        rd_nxt = 8'h00;
      end
    endcase
  end

  // Internal RAM storage
  always_ff @(posedge clk_i)
  begin
    if (accept && iwe)
      iram[iaddr] <= iwdata; // RULE4
  end

  // On-chip external RAM storage
  always_ff @(posedge clk_i)
  begin
    if (accept && xmove && req_i.we && !offchip && !flash_wr)
      external_space_ram[xaddr[XAW-1:0]] <= req_i.wdata; // RULE13 RULE3
  end

  // Stack pointer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sp_r <= `DMAD_SP_RST; // RULE11
    else if (accept && req_i.kind == K_STACK)
      sp_r <= req_i.we ? sp_r + 8'h01 : sp_r - 8'h01; // RULE10 RULE21
    else if (wb_wr && wb_adr_i == `DMAD_OFF_SP)
      sp_r <= wb_dat_i[7:0];
  end

  // Software registers
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_r && wb_sel_i[0];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      psw_r <= `DMAD_PSW_RST;
      dpl_r <= 8'h00;
      dph_r <= 8'h00;
      page_r <= 8'h00;
      cfg_r <= `DMAD_CFG_RST;
      timing_r <= `DMAD_TIMING_RST;
    end
    else if (wb_wr)
    begin
      unique case (wb_adr_i)
        `DMAD_OFF_PSW: psw_r <= wb_dat_i[7:0];
        `DMAD_OFF_DPL: dpl_r <= wb_dat_i[7:0]; // RULE15
        `DMAD_OFF_DPH: dph_r <= wb_dat_i[7:0]; // RULE15
        `DMAD_OFF_PAGE: page_r <= wb_dat_i[7:0];
        `DMAD_OFF_CFG: cfg_r <= wb_dat_i[7:0];
        `DMAD_OFF_TIMING: timing_r <= wb_dat_i[7:0];
        default: psw_r <= psw_r;
      endcase
    end
  end

  // Wishbone answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_r <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_r <= wb_cyc_i && wb_stb_i && !wb_ack_r;
      unique case (wb_adr_i)
        `DMAD_OFF_PSW: wb_dat_o <= {24'h0, psw_r};
        `DMAD_OFF_SP: wb_dat_o <= {24'h0, sp_r};
        `DMAD_OFF_DPL: wb_dat_o <= {24'h0, dpl_r};
        `DMAD_OFF_DPH: wb_dat_o <= {24'h0, dph_r};
        `DMAD_OFF_PAGE: wb_dat_o <= {24'h0, page_r};
        `DMAD_OFF_CFG: wb_dat_o <= {24'h0, cfg_r};
        `DMAD_OFF_TIMING: wb_dat_o <= {24'h0, timing_r};
        `DMAD_OFF_STATUS: wb_dat_o <= {30'h0, offchip_r, (state_r == ST_WAIT)};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end
  assign wb_ack_o = wb_ack_r;

  // Off-chip read data synchroniser
  always_ff @(posedge clk_i)
  begin
    ext_s1_r <= ext_rdata_i;
    ext_s2_r <= ext_s1_r;
  end

  // Request sequencing and off-chip wait
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
      done_o <= 1'b0;
      rdata_o <= 8'h00;
      offchip_r <= 1'b0;
      ext_o <= '0;
      sfr_o <= '0;
      flash_o <= '0;
    end
    else
    begin
      done_o <= 1'b0;
      ext_o.req <= 1'b0;
      sfr_o.req <= 1'b0;
      flash_o.req <= 1'b0;
      unique case (state_r)
        ST_IDLE:
        begin
          if (accept)
          begin
            if (xmove && req_i.we && flash_wr)
              flash_o <= '{1'b1, 1'b1, xaddr, req_i.wdata}; // RULE3
            if (xmove && offchip && !(req_i.we && flash_wr))
            begin
              ext_o <= '{1'b1, req_i.we, xaddr, req_i.wdata};
              cnt_r <= timing_r; // RULE17
              offchip_r <= 1'b1;
              state_r <= ST_WAIT;
            end
            else
            begin
              done_o <= 1'b1; // RULE17
              rdata_o <= rd_nxt;
              offchip_r <= 1'b0;
            end
            if (sfr_sel)
              sfr_o <= '{1'b1, req_i.we && req_i.kind == K_DIRECT, {8'h00, iaddr},
                         req_i.kind == K_BIT ? iwdata : req_i.wdata};
          end
        end
        ST_WAIT:
        begin
          if (cnt_r == 8'h00)
          begin
            done_o <= 1'b1;
            rdata_o <= ext_s2_r;
            state_r <= ST_IDLE;
          end
          else
            cnt_r <= cnt_r - 8'h01;
        end
      endcase
    end
  end

  // Code reads always come from flash
  dmad_code_map #(
    .FLASH_TOP(FLASH_TOP)
  ) u_code_map (
    .addr_i(code_addr_i),
    .flash_o(cflash),
    .lock_o(clock_hit),
    .reserved_o(creserved)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      code_flash_addr_o <= 16'h0;
      code_lock_o <= 1'b0;
      code_reserved_o <= 1'b0;
    end
    else
    begin
      code_flash_addr_o <= code_addr_i; // RULE3
      code_lock_o <= clock_hit; // RULE2
      code_reserved_o <= creserved && !cflash; // RULE1 RULE2
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_sp_reset: assert property ($past(rst_i) |-> sp_r == 8'h07) // RULE11
    else $error("stack pointer not 0x07 after reset");
  a_push_incr: assert property (accept && req_i.kind == K_STACK && req_i.we // RULE10
    |-> iaddr == sp_r + 8'h01 ##1 sp_r == $past(sp_r) + 8'h01)
    else $error("push slot or increment wrong");
  a_pop_decr: assert property (accept && req_i.kind == K_STACK && !req_i.we // RULE21
    |-> iaddr == sp_r ##1 sp_r == $past(sp_r) - 8'h01)
    else $error("pop slot or decrement wrong");
  a_bank_addr: assert property (accept && req_i.kind == K_REG // RULE6
    |-> iaddr[7:5] == 3'h0 && iaddr[4:3] == psw_r[4:3])
    else $error("bank register address wrong");
  a_direct_sfr: assert property (accept && req_i.kind == K_DIRECT && req_i.addr[7] // RULE5
    |-> !iwe ##1 sfr_o.req)
    else $error("upper direct access missed SFR space");
  a_indir_ram: assert property (accept && req_i.kind == K_INDIRECT // RULE5
    |-> !sfr_sel && iaddr == iram[{3'h0, psw_r[4:3], 2'h0, req_i.ri_sel}])
    else $error("indirect access not to RAM via pointer");
  a_bit_map: assert property (accept && req_i.kind == K_BIT && !req_i.addr[7] // RULE8
    |-> iaddr == 8'h20 + {4'h0, req_i.addr[6:3]})
    else $error("bit address maps to wrong byte");
  a_mode_wrap: assert property (accept && xmove && cfg_r[3:2] == 2'h0 // RULE20
    |=> done_o && !ext_o.req)
    else $error("mode 00 move went off-chip");
  a_xri_page: assert property (accept && req_i.kind == K_XRI // RULE16
    |-> xaddr[15:8] == page_r)
    else $error("8-bit move high byte not page register");
  a_offchip_done: assert property (ext_o.req |-> ##[0:256] done_o) // RULE17
    else $error("off-chip move never completed");
  a_wb_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not acknowledged");

  c_push: cover property (accept && req_i.kind == K_STACK && req_i.we);
  c_bit_write: cover property (accept && req_i.kind == K_BIT && req_i.we);
  c_offchip: cover property (ext_o.req ##[1:20] done_o);
  c_flash_wr: cover property (flash_o.req);
endmodule : dmad_core

/* dmad_params.svh */
// Constants for the data memory address decode block
`ifndef DMAD_PARAMS_SVH
`define DMAD_PARAMS_SVH
`define DMAD_OFF_PSW 8'h00
`define DMAD_OFF_SP 8'h04
`define DMAD_OFF_DPL 8'h08
`define DMAD_OFF_DPH 8'h0c
`define DMAD_OFF_PAGE 8'h10
`define DMAD_OFF_CFG 8'h14
`define DMAD_OFF_TIMING 8'h18
`define DMAD_OFF_STATUS 8'h1c
`define DMAD_SP_RST 8'h07
`define DMAD_PSW_RST 8'h00
`define DMAD_CFG_RST 8'h00
`define DMAD_TIMING_RST 8'hff
`define DMAD_BANK_LSB 3
`define DMAD_BANK_MSB 4
`define DMAD_MODE_LSB 2
`define DMAD_MODE_MSB 3
`define DMAD_CFG_FLASH_WE 0
`define DMAD_UPPER_BASE 8'h80
`define DMAD_BIT_BASE 8'h20
`define DMAD_MODE_ONCHIP 2'h0
`define DMAD_MODE_OFFCHIP 2'h3
`define DMAD_FLASH_TOP_BIG 16'hfbff
`define DMAD_FLASH_TOP_SMALL 16'h7fff
`endif

/* dmad_pkg.sv */
// Types for the data memory address decode block
package dmad_pkg;
  typedef enum logic [2:0] {
    K_DIRECT = 3'h0,
    K_INDIRECT = 3'h1,
    K_BIT = 3'h2,
    K_REG = 3'h3,
    K_STACK = 3'h4,
    K_XDP = 3'h5,
    K_XRI = 3'h6
  } dmad_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } dmad_state_t;

  typedef struct packed {
    logic valid;
    dmad_kind_t kind;
    logic we;
    logic ri_sel;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dmad_req_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dmad_xfer_t;
endpackage : dmad_pkg

/* dmad_code_map.sv */
// Program space decode for code reads
`timescale 1ns/1ps
module dmad_code_map
  import dmad_pkg::*;
#(
  parameter logic [15:0] FLASH_TOP = 16'hfbff
)
(
  // Program address
  input wire logic [15:0] addr_i,
  // Decode
  output logic flash_o,
  output logic lock_o,
  output logic reserved_o
);
  always_comb
  begin
    flash_o = (addr_i <= FLASH_TOP); // RULE1
    lock_o = (addr_i == FLASH_TOP); // RULE2
    reserved_o = (addr_i > FLASH_TOP); // RULE2
  end
endmodule : dmad_code_map

/* dmad_far_model.sv */
// Off-chip device and SFR read source facing the decode block
`timescale 1ns/1ps
module dmad_far_model
  import dmad_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Block side
  input wire dmad_xfer_t ext_i,
  output logic [7:0] ext_rdata_o,
  output logic [7:0] sfr_rdata_o,
  output logic [15:0] last_addr_o
);
  logic [7:0] val_r;
  logic [3:0] hold_r;
  assign sfr_rdata_o = 8'h3c;
  // Data shown only inside the hold window
  assign ext_rdata_o = (hold_r != 4'h0) ? val_r : ~val_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hold_r <= 4'h0;
      val_r <= 8'h00;
      last_addr_o <= 16'h0000;
    end
    else if (ext_i.req)
    begin
      val_r <= ext_i.addr[7:0] ^ 8'h5a;
      last_addr_o <= ext_i.addr;
      hold_r <= 4'h8;
    end
    else if (hold_r != 4'h0)
    begin
      hold_r <= hold_r - 4'h1;
    end
  end
endmodule : dmad_far_model

/* data_memory_address_decode_tb.sv */
// Self-checking bench for the data memory address decode block
`timescale 1ns/1ps
`include "dmad_params.svh"
module data_memory_address_decode_tb
  import dmad_pkg::*;
;
  typedef struct {dmad_kind_t k; logic we; logic [15:0] a; logic [7:0] d; logic [7:0] e;} dmad_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, ready_o, done_o, code_lock_o, code_reserved_o;
  dmad_req_t req_i = '0;
  logic [7:0] rdata_o, sfr_rdata_i, ext_rdata_i, q;
  logic [15:0] code_addr_i = 16'h0000;
  logic [15:0] code_flash_addr_o, far_addr, flash_seen;
  dmad_xfer_t sfr_o, flash_o, ext_o;
  int mismatches = 0;
  int checks_done = 0;
  int n;
  dmad_row_t rows [14] = '{
    '{K_STACK, 1'b1, 16'h0000, 8'h5a, 8'h00}, '{K_DIRECT, 1'b0, 16'h0008, 8'h00, 8'h5a},
    '{K_STACK, 1'b0, 16'h0000, 8'h00, 8'h5a}, '{K_DIRECT, 1'b1, 16'h0025, 8'h00, 8'h00},
    '{K_BIT, 1'b1, 16'h002b, 8'h01, 8'h00}, '{K_DIRECT, 1'b0, 16'h0025, 8'h00, 8'h08},
    '{K_BIT, 1'b0, 16'h002b, 8'h00, 8'h01}, '{K_REG, 1'b1, 16'h0000, 8'h90, 8'h00},
    '{K_INDIRECT, 1'b1, 16'h0090, 8'hc3, 8'h00}, '{K_INDIRECT, 1'b0, 16'h0090, 8'h00, 8'hc3},
    '{K_DIRECT, 1'b0, 16'h0090, 8'h00, 8'h3c}, '{K_DIRECT, 1'b1, 16'h0040, 8'h11, 8'h00},
    '{K_REG, 1'b1, 16'h0000, 8'h40, 8'h00}, '{K_INDIRECT, 1'b0, 16'h0040, 8'h00, 8'h11}};

  dmad_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_i(req_i), .ready_o(ready_o),
    .done_o(done_o), .rdata_o(rdata_o), .code_addr_i(code_addr_i),
    .code_flash_addr_o(code_flash_addr_o), .code_lock_o(code_lock_o),
    .code_reserved_o(code_reserved_o), .sfr_o(sfr_o), .sfr_rdata_i(sfr_rdata_i),
    .flash_o(flash_o), .ext_o(ext_o), .ext_rdata_i(ext_rdata_i));
  dmad_far_model far_u (.clk_i(clk_i), .rst_i(rst_i), .ext_i(ext_o),
    .ext_rdata_o(ext_rdata_i), .sfr_rdata_o(sfr_rdata_i), .last_addr_o(far_addr));

  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    if (flash_o.req === 1'b1)
      flash_seen <= flash_o.addr;
  end

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task wb(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    i = 0;
    do
    begin
      @(posedge clk_i);
      i++;
    end
    while (wb_ack_o !== 1'b1 && i < 300);
    r = wb_dat_o[7:0];
    if (i >= 300)
      mismatches++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task op(input dmad_kind_t k, input logic we, input logic ri, input logic [15:0] a,
          input logic [7:0] d, output logic [7:0] r, output int c);
    @(posedge clk_i);
    req_i <= '{1'b1, k, we, ri, a, d};
    do
      @(posedge clk_i);
    while (ready_o !== 1'b1);
    req_i.valid <= 1'b0;
    c = 0;
    do
    begin
      @(posedge clk_i);
      c++;
    end
    while (done_o !== 1'b1 && c < 300);
    if (c >= 300)
      mismatches++;
    r = rdata_o;
  endtask : op

  task finish_test;
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    finish_test;
  end

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `DMAD_OFF_SP, 8'h00, q);
    chk("sp_reset", 16'h0007, {8'h0, q});
    wb(1'b0, `DMAD_OFF_TIMING, 8'h00, q);
    chk("timing_reset", 16'h00ff, {8'h0, q});
    foreach (rows[i])
    begin
      op(rows[i].k, rows[i].we, 1'b0, rows[i].a, rows[i].d, q, n);
      chk("row_lat", 16'h0001, n[15:0]);
      if (!rows[i].we)
        chk("row_data", {8'h0, rows[i].e}, {8'h0, q});
    end
    chk("sfr_addr", 16'h0090, sfr_o.addr);
    for (int b = 0; b < 4; b++)
    begin
      wb(1'b1, `DMAD_OFF_PSW, 8'(b << 3), q);
      op(K_REG, 1'b1, 1'b0, 16'h0002, 8'(8'h70 + b), q, n);
      op(K_DIRECT, 1'b0, 1'b0, 16'(8 * b + 2), 8'h00, q, n);
      chk("bank_reg", 16'(8'h70 + b), {8'h0, q});
    end
    wb(1'b1, `DMAD_OFF_PSW, 8'h00, q);
    wb(1'b1, `DMAD_OFF_SP, 8'hfe, q);
    op(K_STACK, 1'b1, 1'b0, 16'h0000, 8'he7, q, n);
    op(K_REG, 1'b1, 1'b0, 16'h0000, 8'hff, q, n);
    op(K_INDIRECT, 1'b0, 1'b0, 16'h00ff, 8'h00, q, n);
    chk("stack_high", 16'h00e7, {8'h0, q});
    wb(1'b0, `DMAD_OFF_SP, 8'h00, q);
    chk("sp_after_push", 16'h00ff, {8'h0, q});
    wb(1'b1, `DMAD_OFF_DPL, 8'h34, q);
    wb(1'b1, `DMAD_OFF_DPH, 8'h12, q);
    wb(1'b0, `DMAD_OFF_DPL, 8'h00, q);
    chk("dp_low", 16'h0034, {8'h0, q});
    wb(1'b0, `DMAD_OFF_DPH, 8'h00, q);
    chk("dp_high", 16'h0012, {8'h0, q});
    op(K_XDP, 1'b1, 1'b0, 16'h0000, 8'ha5, q, n);
    wb(1'b1, `DMAD_OFF_PAGE, 8'h12, q);
    op(K_REG, 1'b1, 1'b0, 16'h0001, 8'h34, q, n);
    op(K_XRI, 1'b0, 1'b1, 16'h0000, 8'h00, q, n);
    chk("xri_read", 16'h00a5, {8'h0, q});
    wb(1'b1, `DMAD_OFF_DPH, 8'h02, q);
    op(K_XDP, 1'b0, 1'b0, 16'h0000, 8'h00, q, n);
    chk("wrap_read", 16'h00a5, {8'h0, q});
    wb(1'b1, `DMAD_OFF_CFG, 8'h01, q);
    op(K_XDP, 1'b1, 1'b0, 16'h0000, 8'h77, q, n);
    @(posedge clk_i);
    chk("flash_addr", 16'h0234, flash_seen);
    wb(1'b1, `DMAD_OFF_CFG, 8'h00, q);
    op(K_XDP, 1'b0, 1'b0, 16'h0000, 8'h00, q, n);
    chk("external_space_ram_kept", 16'h00a5, {8'h0, q});
    wb(1'b1, `DMAD_OFF_TIMING, 8'h03, q);
    wb(1'b1, `DMAD_OFF_CFG, 8'h0c, q);
    wb(1'b1, `DMAD_OFF_DPH, 8'h12, q);
    op(K_XDP, 1'b0, 1'b0, 16'h0000, 8'h00, q, n);
    chk("off_lat", 16'h0005, n[15:0]);
    chk("off_addr", 16'h1234, far_addr);
    chk("off_data", 16'h006e, {8'h0, q});
    wb(1'b0, 8'h20, 8'h00, q);
    chk("unmapped", 16'h0000, {8'h0, q});
    wb(1'b0, `DMAD_OFF_STATUS, 8'h00, q);
    chk("status", 16'h0002, {8'h0, q});
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `DMAD_OFF_SP, 8'h00, q);
    chk("sp_rereset", 16'h0007, {8'h0, q});
    for (int j = 0; j < 3; j++)
    begin
      @(posedge clk_i);
      code_addr_i <= (j == 0) ? 16'hfbff : (j == 1) ? 16'hfc00 : 16'h1000;
      repeat (2) @(posedge clk_i);
      chk("code_lock", 16'(j == 0), {15'h0, code_lock_o});
      chk("code_rsvd", 16'(j == 1), {15'h0, code_reserved_o});
      if (j == 2)
        chk("code_addr", 16'h1000, code_flash_addr_o);
    end
    finish_test;
  end
endmodule : data_memory_address_decode_tb
